/* File: bench/pflash_protection_chk.sv */
// Port checker for the program flash protection block
module pflash_protection_chk #(
  parameter AW = 24
) (
  input wire          core_clk,
  input wire          rst,
  input wire [2:0]    reg_addr,
  input wire [7:0]    reg_wdata,
  input wire          reg_wr,
  input wire          reg_rd,
  input wire [7:0]    reg_rdata,
  input wire          cfg_rd_req,
  input wire [AW-1:0] cfg_rd_addr,
  input wire          cfg_rd_valid,
  input wire          cmd_req,
  input wire          cmd_accept,
  input wire          cmd_reject,
  input wire          load_done
);
  logic viol_q;
  // Sets one cycle after the real flag and clears with it, so it never fires early
  always @(posedge core_clk or posedge rst) begin
    if (rst) viol_q <= 1'b0;
    else if (cmd_reject) viol_q <= 1'b1;
    else if (reg_wr && reg_addr == 3'h1 && reg_wdata[4]) viol_q <= 1'b0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_adr; cfg_rd_req |-> cfg_rd_addr == 24'hFF_FE0C; endproperty
  a_adr: assert property (p_adr) else $error("bad fetch address");
  property p_hold; cfg_rd_req && !cfg_rd_valid |=> cfg_rd_req; endproperty
  a_hold: assert property (p_hold) else $error("fetch dropped");
  property p_load;
    cfg_rd_req && cfg_rd_valid |=> load_done && !cfg_rd_req;
  endproperty
  a_load: assert property (p_load) else $error("load not done");
  property p_done; load_done |=> load_done; endproperty
  a_done: assert property (p_done) else $error("load done lost");
  property p_ans; cmd_req && load_done |=> cmd_accept != cmd_reject;
  endproperty
  a_ans: assert property (p_ans) else $error("no verdict");
  property p_only;
    cmd_accept || cmd_reject |-> $past(cmd_req) && $past(load_done);
  endproperty
  a_only: assert property (p_only) else $error("stray verdict");
  property p_viol; cmd_req && load_done && viol_q |=> cmd_reject;
  endproperty
  a_viol: assert property (p_viol) else $error("launch not blocked");
  property p_rd0; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rd0: assert property (p_rd0) else $error("read data not idle");
endmodule

/* File: bench/program_flash_protection_register_tb_top.sv */
// Testbench for the program flash protection block
module program_flash_protection_register_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk, rst, special_mode, reg_wr, reg_rd, er, e;
  logic        cfg_rd_valid, cfg_rd_dfault, cfg_rd_req, load_done, irq;
  logic        cmd_req, cmd_is_erase_blk, cmd_accept, cmd_reject, rd_q, cmd_q;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, cfg_rd_data, pv, nv, ev;
  logic [23:0] cfg_rd_addr, cmd_addr, a, lo, hi;
  logic [7:0]  exp_q[$];
  logic [7:0]  ok_m[8] = '{8'h0F, 8'h0A, 8'h0C, 8'h08,
                           8'h18, 8'h3C, 8'h5A, 8'hFF};
  int          miscompares, comparisons, f, t, i;
  pflash_protection i_dut (
    .core_clk(core_clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .special_mode(special_mode),
    .cfg_rd_req(cfg_rd_req), .cfg_rd_addr(cfg_rd_addr),
    .cfg_rd_valid(cfg_rd_valid), .cfg_rd_data(cfg_rd_data),
    .cfg_rd_dfault(cfg_rd_dfault), .cmd_req(cmd_req),
    .cmd_is_erase_blk(cmd_is_erase_blk), .cmd_addr(cmd_addr),
    .cmd_accept(cmd_accept), .cmd_reject(cmd_reject),
    .load_done(load_done), .irq(irq)
  );
  initial begin
    core_clk = 0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail_out;
    miscompares++;
    wrap_up;
  endtask
  task automatic bus(input logic w, input logic [2:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= w;
    reg_rd    <= !w;
    @(posedge core_clk);
    reg_wr    <= 0;
    reg_rd    <= 0;
  endtask
  task automatic rd(input logic [2:0] ad, input logic [7:0] x);
    exp_q.push_back(x);
    bus(0, ad, 8'h00);
  endtask
  task automatic cmd(input logic [23:0] ad, input logic b, input logic [7:0] x);
    exp_q.push_back(x);
    @(posedge core_clk);
    cmd_req          <= 1;
    cmd_addr         <= ad;
    cmd_is_erase_blk <= b;
    @(posedge core_clk);
    cmd_req          <= 0;
  endtask
  // Mode pin is synchronised, so give it time to land
  task automatic sm(input logic v);
    special_mode <= v;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic boot(input logic [7:0] d, input logic df);
    @(posedge core_clk);
    rst <= 1;
    repeat (4) @(posedge core_clk);
    rst <= 0;
    for (i = 0; i < 20 && !cfg_rd_req; i++) @(negedge core_clk);
    if (!cfg_rd_req) fail_out;
    @(posedge core_clk);
    cfg_rd_data   <= d;
    cfg_rd_dfault <= df;
    cfg_rd_valid  <= 1;
    @(posedge core_clk);
    cfg_rd_valid  <= 0;
    cfg_rd_data   <= ~d;
    cfg_rd_dfault <= 0;
    for (i = 0; i < 20 && !load_done; i++) @(negedge core_clk);
    if (!load_done) fail_out;
  endtask
  always @(posedge core_clk) begin
    if (rd_q) check(reg_rdata, exp_q.pop_front());
    if (cmd_q) check({6'h00, cmd_accept, cmd_reject}, exp_q.pop_front());
    rd_q  <= reg_rd;
    cmd_q <= cmd_req;
  end
  initial begin
    {rst, special_mode, reg_wr, reg_rd, cfg_rd_valid} = 5'h10;
    {cfg_rd_dfault, cmd_req, cmd_is_erase_blk} = 3'h0;
    {reg_addr, reg_wdata, cfg_rd_data, cmd_addr} = '0;
    pv = $urandom(32'hc984_fd51);
    boot(pv, 1);
    rd(0, 8'h7F);
    boot(8'hFF, 0);
    rd(0, 8'hFF);
    rd(7, 8'h00);
    for (f = 0; f < 8; f++) begin
      for (t = 0; t < 8; t++) begin
        pv = $urandom | 8'h40;
        nv = $urandom | 8'h40;
        {pv[7], pv[5], pv[2]} = f[2:0];
        {nv[7], nv[5], nv[2]} = t[2:0];
        sm(1);
        bus(1, 0, pv);
        sm(0);
        bus(1, 0, nv);
        ev = {nv[7:5], pv[5] ? nv[4:3] : pv[4:3],
              nv[2], pv[2] ? nv[1:0] : pv[1:0]};
        rd(0, ok_m[f][t] ? ev : pv);
      end
    end
    for (i = 0; i < 80; i++) begin
      pv = $urandom;
      sm(1);
      bus(1, 0, pv);
      sm(0);
      lo = 24'hFF_8000 + (24'h00_0400 << pv[1:0]);
      hi = 24'h00_0000 - (24'h00_0800 << pv[4:3]);
      case ($urandom % 4)
        0: a = lo - $urandom % 2;
        1: a = hi - $urandom % 2;
        default: a = 24'hFF_8000 + $urandom % 32'h0000_8000;
      endcase
      er = $urandom % 4 == 0;
      e = (!pv[5] && a >= hi) || (!pv[2] && a < lo);
      e = er ? !(pv[7] && pv[5] && pv[2]) : e ^ !pv[7];
      cmd(a, er, {6'h00, !e, e});
      if (e) bus(1, 1, 8'h10);
    end
    @(negedge core_clk);
    check({7'h00, irq}, 8'h00);
    bus(1, 3, 8'h01);
    sm(1);
    bus(1, 0, 8'h24);
    sm(0);
    cmd(24'hFF_9000, 0, 8'h01);
    sm(1);
    bus(1, 0, 8'hE4);
    sm(0);
    check({7'h00, irq}, 8'h01);
    cmd(24'hFF_9000, 0, 8'h01);
    bus(1, 1, 8'h00);
    rd(1, 8'h10);
    bus(1, 1, 8'h10);
    rd(1, 8'h00);
    cmd(24'hFF_9000, 0, 8'h02);
    rd(2, 8'h07);
    bus(1, 4, 8'h07);
    rd(2, 8'h00);
    repeat (3) @(negedge core_clk);
    check({7'h00, irq}, 8'h00);
    wrap_up;
  end
endmodule
bind pflash_protection pflash_protection_chk #(.AW(AW)) i_chk (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cfg_rd_req(cfg_rd_req),
  .cfg_rd_addr(cfg_rd_addr), .cfg_rd_valid(cfg_rd_valid),
  .cmd_req(cmd_req), .cmd_accept(cmd_accept),
  .cmd_reject(cmd_reject), .load_done(load_done)
);

/* File: src/cfg_byte_reg.v */
// Holding register for the configuration byte fetched at reset
module cfg_byte_reg #(
  parameter W = 8
) (
  input  wire         core_clk,
  input  wire         rst,
  input  wire         ce,
  input  wire         wr_en,
  input  wire [W-1:0] wr_data,
  output reg  [W-1:0] rd_data
);
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= {W{1'b1}};
    end else if (ce && wr_en) begin
      rd_data <= wr_data;
    end
  end
endmodule

/* File: src/pflash_prot_consts.vh */
// Constants for the program flash protection register block
`ifndef PFLASH_PROT_CONSTS_VH
`define PFLASH_PROT_CONSTS_VH

`define ADDR_PROT       3'h0
`define ADDR_STATUS     3'h1
`define ADDR_IRQ_STAT   3'h2
`define ADDR_IRQ_EN     3'h3
`define ADDR_IRQ_CLR    3'h4
`define ADDR_MODE       3'h5

`define BIT_OPEN        7
`define BIT_RNV         6
`define BIT_HDIS        5
`define HS_HI           4
`define HS_LO           3
`define BIT_LDIS        2
`define LS_HI           1
`define LS_LO           0

`define STAT_VIOL       4

`define CFG_ADDR        24'hFF_FE0C
`define ARRAY_BASE      24'hFF_8000
`define ARRAY_TOP       24'hFF_FFFF
`define HIGH_MIN_SIZE   24'h00_0800
`define LOW_MIN_SIZE    24'h00_0400
`define BLOCK_SIZE      24'h00_8000
`define DFAULT_VALUE    8'h7F
`define PROT_RESET      8'h7F

`define IRQ_VIOL        0
`define IRQ_LOADED      1
`define IRQ_REJECT      2
`define IRQ_W           3

`endif

/* File: src/pflash_protection.v */
// Program flash protection register and command guard
`include "pflash_prot_consts.vh"

// Operation
// (RULE1) Normal mode only accepts writes adding protection
// (RULE2) Special mode writes all unreserved bits freely
// (RULE3) Reset sequence loads register from config byte
// (RULE4) Double fault at reset gives full protection
// (RULE5) Protected program or erase sets violation flag
// (RULE6) Block erase refused if block partly protected
// (RULE7) Field layout open, rnv, hdis, hs, ldis, ls
// (RULE8) Open bit selects protected or open windows
// (RULE9) Disable bit one removes its range
// (RULE10) High range ends at top, 2 to 16 KB
// (RULE11) Low range starts at base, 1 to 8 KB
// (RULE12) High size writable only while high disabled
// (RULE13) Low size writable only while low disabled
// (RULE14) Disallowed scenario transition ignores whole write
// (RULE15) Reads return the enforced scenario
// (RULE16) Software leaves reserved bit erased
// (RULE17) Software unprotects top sector before reprogramming
// (RULE18) Violation flag cleared by one, blocks launches
// (RULE19) Scenario index is open, hdis, ldis
module pflash_protection #(
  parameter AW = 24
) (
  input  wire          core_clk,
  input  wire          rst,
  input  wire          ce,
  input  wire [2:0]    reg_addr,
  input  wire [7:0]    reg_wdata,
  input  wire          reg_wr,
  input  wire          reg_rd,
  output reg  [7:0]    reg_rdata,
  input  wire          special_mode,
  output reg           cfg_rd_req,
  output reg  [AW-1:0] cfg_rd_addr,
  input  wire          cfg_rd_valid,
  input  wire [7:0]    cfg_rd_data,
  input  wire          cfg_rd_dfault,
  input  wire          cmd_req,
  input  wire          cmd_is_erase_blk,
  input  wire [AW-1:0] cmd_addr,
  output reg           cmd_accept,
  output reg           cmd_reject,
  output reg           load_done,
  output reg           irq
);
  localparam S_REQ  = 2'd0;
  localparam S_WAIT = 2'd1;
  localparam S_RUN  = 2'd2;

  reg [1:0]    state_q;
  reg [7:0]    prot_q;
  reg          viol_q;
  reg [`IRQ_W-1:0] irq_stat_q;
  reg [`IRQ_W-1:0] irq_en_q;
  reg          mode_q1;
  reg          mode_q2;
  reg          cfg_we;
  reg  [7:0]   cfg_wd;
  wire [7:0]   cfg_hold;

  cfg_byte_reg #(.W(8)) u_cfg (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .wr_en    (cfg_we),
    .wr_data  (cfg_wd),
    .rd_data  (cfg_hold)
  );

  // Scenario index
  function [2:0] scen;
    input [7:0] v;
    begin
      scen = {v[`BIT_OPEN], v[`BIT_HDIS], v[`BIT_LDIS]}; // (RULE19)
    end
  endfunction

  // Allowed transitions, row = from
  function allowed;
    input [2:0] from;
    input [2:0] to;
    reg   [7:0] row;
    begin
      case (from) // (RULE14)
        3'd0:    row = 8'h0F;
        3'd1:    row = 8'h0A;
        3'd2:    row = 8'h0C;
        3'd3:    row = 8'h08;
        3'd4:    row = 8'h18;
        3'd5:    row = 8'h3C;
        3'd6:    row = 8'h5A;
        default: row = 8'hFF;
      endcase
      allowed = row[to];
    end
  endfunction

  // Range hit tests on the currently enforced value
  function in_high;
    input [7:0]    v;
    input [AW-1:0] a;
    reg   [AW-1:0] sz;
    begin
      sz = `HIGH_MIN_SIZE << v[`HS_HI:`HS_LO]; // (RULE10)
      in_high = (a > (`ARRAY_TOP - sz)) && (a <= `ARRAY_TOP);
    end
  endfunction

  function in_low;
    input [7:0]    v;
    input [AW-1:0] a;
    reg   [AW-1:0] sz;
    begin
      sz = `LOW_MIN_SIZE << v[`LS_HI:`LS_LO]; // (RULE11)
      in_low = (a >= `ARRAY_BASE) && (a < (`ARRAY_BASE + sz));
    end
  endfunction

  function is_prot;
    input [7:0]    v;
    input [AW-1:0] a;
    reg            hit;
    begin
      hit = (!v[`BIT_HDIS] && in_high(v, a)) ||
            (!v[`BIT_LDIS] && in_low(v, a)); // (RULE9)
      is_prot = v[`BIT_OPEN] ? hit : !hit; // (RULE8)
    end
  endfunction

  // Any sector protected inside the block holding the address
  function blk_prot;
    input [7:0]    v;
    input [AW-1:0] a;
    reg            any;
    begin
      if (!v[`BIT_OPEN]) begin
        any = 1'b1; // Outside the open windows is always protected
      end else begin
        any = !v[`BIT_HDIS] || !v[`BIT_LDIS];
      end
      blk_prot = any && (a >= `ARRAY_BASE); // (RULE6)
    end
  endfunction

  // Candidate value of a normal mode write
  reg  [7:0] cand;
  reg        wr_ok;
  always @* begin
    cand = prot_q;
    cand[`BIT_OPEN] = reg_wdata[`BIT_OPEN]; // (RULE7)
    cand[`BIT_HDIS] = reg_wdata[`BIT_HDIS];
    cand[`BIT_LDIS] = reg_wdata[`BIT_LDIS];
    if (prot_q[`BIT_HDIS]) begin
      cand[`HS_HI:`HS_LO] = reg_wdata[`HS_HI:`HS_LO]; // (RULE12)
    end
    if (prot_q[`BIT_LDIS]) begin
      cand[`LS_HI:`LS_LO] = reg_wdata[`LS_HI:`LS_LO]; // (RULE13)
    end
    wr_ok = allowed(scen(prot_q), scen(cand)); // (RULE1)
  end

  wire prot_wr = reg_wr && (reg_addr == `ADDR_PROT) && (state_q == S_RUN);
  wire cmd_go  = cmd_req && (state_q == S_RUN);
  wire cmd_bad = viol_q || (cmd_is_erase_blk ?
                 blk_prot(prot_q, cmd_addr) : is_prot(prot_q, cmd_addr));
  wire viol_set = cmd_go && !viol_q && cmd_bad;
  wire viol_clr = reg_wr && (reg_addr == `ADDR_STATUS) &&
                  reg_wdata[`STAT_VIOL];
  wire rej_ev   = prot_wr && !mode_q2 && !wr_ok;

  always @* begin
    cfg_we = 1'b0;
    cfg_wd = cfg_rd_data;
    if (state_q == S_WAIT && cfg_rd_valid) begin
      cfg_we = 1'b1;
      cfg_wd = cfg_rd_dfault ? `DFAULT_VALUE : cfg_rd_data; // (RULE4)
    end
  end

  wire [`IRQ_W-1:0] ev = {rej_ev, (state_q == S_WAIT) && cfg_rd_valid,
                          viol_set};

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= S_REQ;
      prot_q      <= `PROT_RESET;
      viol_q      <= 1'b0;
      irq_stat_q  <= {`IRQ_W{1'b0}};
      irq_en_q    <= {`IRQ_W{1'b0}};
      mode_q1     <= 1'b0;
      mode_q2     <= 1'b0;
      cfg_rd_req  <= 1'b0;
      cfg_rd_addr <= {AW{1'b0}};
      cmd_accept  <= 1'b0;
      cmd_reject  <= 1'b0;
      load_done   <= 1'b0;
      reg_rdata   <= 8'h00;
      irq         <= 1'b0;
    end else if (ce) begin
      // Mode strap comes from a pin
      mode_q1    <= special_mode;
      mode_q2    <= mode_q1;
      cmd_accept <= 1'b0;
      cmd_reject <= 1'b0;
      case (state_q)
        S_REQ: begin
          cfg_rd_req  <= 1'b1;
          cfg_rd_addr <= `CFG_ADDR; // (RULE3)
          state_q     <= S_WAIT;
        end
        S_WAIT: begin
          if (cfg_rd_valid) begin
            cfg_rd_req <= 1'b0;
            prot_q     <= cfg_wd; // (RULE3)
            load_done  <= 1'b1;
            state_q    <= S_RUN;
          end
        end
        S_RUN: begin
          if (prot_wr) begin
            if (mode_q2) begin
              prot_q <= {reg_wdata[7], prot_q[`BIT_RNV],
                         reg_wdata[5:0]}; // (RULE2)
            end else if (wr_ok) begin
              prot_q <= cand; // (RULE1)
            end
          end
          if (cmd_go) begin
            cmd_accept <= !cmd_bad;
            cmd_reject <= cmd_bad; // (RULE5)
          end
        end
        default: state_q <= S_REQ;
      endcase
      // Set wins over clear
      viol_q <= viol_set | (viol_q & ~viol_clr); // (RULE18)
      if (reg_wr && reg_addr == `ADDR_IRQ_EN) begin
        irq_en_q <= reg_wdata[`IRQ_W-1:0];
      end
      if (reg_wr && reg_addr == `ADDR_IRQ_CLR) begin
        irq_stat_q <= ev | (irq_stat_q & ~reg_wdata[`IRQ_W-1:0]);
      end else begin
        irq_stat_q <= ev | irq_stat_q;
      end
      irq <= |(irq_stat_q & irq_en_q);
      if (reg_rd) begin
        case (reg_addr)
          `ADDR_PROT:     reg_rdata <= prot_q; // (RULE15)
          `ADDR_STATUS:   reg_rdata <= {3'b000, viol_q, 4'h0};
          `ADDR_IRQ_STAT: reg_rdata <= {{(8-`IRQ_W){1'b0}}, irq_stat_q};
          `ADDR_IRQ_EN:   reg_rdata <= {{(8-`IRQ_W){1'b0}}, irq_en_q};
          `ADDR_MODE:     reg_rdata <= {6'h00, load_done, mode_q2};
          default:        reg_rdata <= 8'h00;
        endcase
      end else begin
        reg_rdata <= 8'h00;
      end
    end
  end

  // Last fetched config byte kept for debug visibility of cfg_hold
  wire unused_cfg = ^cfg_hold;
endmodule
